//--- shared/scdc_pkg.sv
`default_nettype none
package scdc_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_STAT = 12'h050;
   localparam logic [11:0] OFS_BASE = 12'h060;
   localparam logic [11:0] OFS_XLAT = 12'h064;
   localparam logic [11:0] OFS_EXT  = 12'h070;
   localparam logic [11:0] OFS_GATE = 12'h104;
   localparam logic [11:0] OFS_DSLP = 12'h144;

   // field positions and widths
   localparam int SRC_W      = 2;
   localparam int CRYSTAL_SELECT_FIELD_W     = 4;
   localparam int DIV_W      = 4;
   localparam int DIV2_W     = DIV_W + 2;
   localparam int DVSR_W     = 7;
   localparam int XLAT_W     = 14;
   localparam int CNT_W      = 16;
   localparam int B_MAIN_OSCILLATOR_DIS = 0;
   localparam int B_IOSC_DIS = 1;
   localparam int B_DS_EN    = 0;
   localparam int B_SRC_LO   = 4;
   localparam int B_CRYSTAL_SELECT_FIELD_LO  = 6;
   localparam int B_BYP      = 11;
   localparam int B_PWRDN    = 13;
   localparam int B_USEDIV   = 22;
   localparam int B_DIV_LO   = 23;
   localparam int B_OVR      = 31;
   localparam int S_RDY      = 0;
   localparam int S_PLLSEL   = 1;
   localparam int S_RSVD     = 2;
   localparam int S_SRC_LO   = 4;
   localparam int S_DVSR_LO  = 8;
   localparam int S_CNT_LO   = 16;

   // reset values and writable masks
   localparam logic [31:0] RST_BASE  = 32'h0780_2AD1;
   localparam logic [31:0] RST_EXT   = 32'h0780_2810;
   localparam logic [31:0] RST_DSLP  = 32'h0000_0000;
   localparam logic [31:0] MASK_BASE = 32'h07C0_2BF3;
   localparam logic [31:0] MASK_EXT  = 32'h9F80_2830;
   localparam logic [31:0] MASK_DSLP = 32'h1F80_0031;

   // divider encodings
   localparam logic [DIV_W-1:0]  DIV_PLL_MIN  = 4'h7;
   localparam logic [DIV_W-1:0]  DIV_PLL_HOLE = 4'h8;
   localparam logic [DIV2_W-1:0] DIV2_PLL_MIN = 6'h09;
   localparam logic [DIV2_W-1:0] DIV_BYP_TWO  = 6'h01;
   localparam logic [DVSR_W-1:0] DVSR_ONE     = 7'h01;
   localparam logic [DVSR_W-1:0] DVSR_TWO     = 7'h02;

   // pll and converter clock figures
   localparam int VCO_MHZ    = 400;
   localparam int PLL_PREDIV = 2;
   localparam int ADC_MHZ    = 16;
   localparam logic [4:0] ADC_DIV = 5'(VCO_MHZ / ADC_MHZ);
   localparam logic [CNT_W-1:0] RELOCK_CNT = 16'h1200;

   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [SRC_W-1:0] {
      SRC_MAIN,
      SRC_INT,
      SRC_INT_QTR,
      SRC_SLOW
   } scdc_src_t;

   typedef struct packed {
      scdc_src_t         src;
      logic              use_pll;
      logic [DVSR_W-1:0] divisor;
   } scdc_sel_t;
endpackage
`default_nettype wire

//--- core/scdc_core.sv
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`default_nettype none
// Summary of operation
// - override bit set makes source, bypass, power-down and divider come from the extended register.
// - converter clock is the vco divided down to 16 MHz, whatever the divisor.
// - divider applies to pll output when bypass is 0, else to source.
// - pll mode halves the 400 MHz vco before the divisor.
// - divisor equals the four-bit divider encoding plus one, /1 to /16.
// - divider resets to 0xF; pll reserved codes; bypassed 0x0 and 0x1 divide by two.
// - divider-use clear with pll unused runs the undivided source.
// - extended divider is two bits wider, up to /64.
// - extended divisor is encoding plus one, on halved pll or source.
// - extended pll codes 0x00-0x08 reserved; bypassed 0x00 and 0x01 divide by two.
// - crystal field is translated to pll settings by hardware.
// - registers hold sources, pll choice, enables, divisors and crystal.
// - each peripheral clock has its own software gate.
// - deep sleep lets the deep-sleep register pick source and divider.
// - internal oscillator is the source from reset until software changes it.
// - pll change loads a 0x1200 down counter; pll unused until expiry.
// - relock on a crystal write only when the crystal field really changes value.
module scdc_core #(
   parameter int                           NPERIPH      = 32,
   parameter logic [scdc_pkg::CNT_W-1:0]   RELOCK_COUNT = scdc_pkg::RELOCK_CNT,
   parameter logic [16*scdc_pkg::XLAT_W-1:0] PLL_XLAT   = '0
) (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   // ahb-lite slave
   input  wire logic                           hsel,
   input  wire logic [31:0]                    haddr,
   input  wire logic [1:0]                     htrans,
   input  wire logic                           hwrite,
   input  wire logic [2:0]                     hsize,
   input  wire logic [31:0]                    hwdata,
   input  wire logic                           hready,
   output var  logic                           hreadyout,
   output var  logic [31:0]                    hrdata,
   output var  logic                           hresp,
   // power mode pin
   input  wire logic                           deep_sleep_req,
   // clock tree controls
   output var  scdc_pkg::scdc_sel_t            clk_sel,
   output var  logic                           main_osc_en,
   output var  logic                           int_osc_en,
   output var  logic                           pll_pwr_on,
   output var  logic [scdc_pkg::XLAT_W-1:0]    pll_xlat,
   output var  logic [4:0]                     adc_clk_div,
   output var  logic [NPERIPH-1:0]             periph_clk_en
);
   generate
      if (NPERIPH < 1 || NPERIPH > 32) begin : g_chk_np
         $error("NPERIPH must be 1 to 32");
      end
      if (RELOCK_COUNT == '0) begin : g_chk_rc
         $error("RELOCK_COUNT must be nonzero");
      end
      if (scdc_pkg::DIV2_W != scdc_pkg::DIV_W + 2) begin : g_chk_dw
         $error("extended divider must be two bits wider");
      end
      if (scdc_pkg::VCO_MHZ % scdc_pkg::ADC_MHZ != 0) begin : g_chk_adc
         $error("converter divide must be whole");
      end
   endgenerate

   localparam int DW  = scdc_pkg::DIV_W;
   localparam int D2W = scdc_pkg::DIV2_W;
   localparam int VW  = scdc_pkg::DVSR_W;

   // registers
   logic [31:0]              base_r, base_nxt;
   logic [31:0]              ext_r, ext_nxt;
   logic [31:0]              dslp_r, dslp_nxt;
   logic [NPERIPH-1:0]       gate_r, gate_nxt;
   logic [scdc_pkg::CNT_W-1:0] relock_r, relock_nxt;
   logic                     pwrdn_prev_r;
   logic                     ds_meta_r, ds_sync_r;
   logic                     dph_wr_r;
   logic [11:0]              dph_addr_r;

   // bus decode
   wire        addr_phase = hsel & htrans[1] & hready;
   // only whole-word transfers are taken
   wire        word_ok    = (hsize == scdc_pkg::HSIZE_WORD);
   wire        wr_base    = dph_wr_r & (dph_addr_r == scdc_pkg::OFS_BASE);
   wire        wr_ext     = dph_wr_r & (dph_addr_r == scdc_pkg::OFS_EXT);
   wire        wr_dslp    = dph_wr_r & (dph_addr_r == scdc_pkg::OFS_DSLP);
   wire        wr_gate    = dph_wr_r & (dph_addr_r == scdc_pkg::OFS_GATE);

   assign base_nxt = wr_base ? (hwdata & scdc_pkg::MASK_BASE) : base_r;
   assign ext_nxt  = wr_ext  ? (hwdata & scdc_pkg::MASK_EXT)  : ext_r;
   assign dslp_nxt = wr_dslp ? (hwdata & scdc_pkg::MASK_DSLP) : dslp_r;
   assign gate_nxt = wr_gate ? hwdata[NPERIPH-1:0] : gate_r;

   // field selection
   localparam int CRYSTAL_SELECT_FIELD_FW = scdc_pkg::CRYSTAL_SELECT_FIELD_W;
   wire                ovr      = ext_r[scdc_pkg::B_OVR];
   wire                ds_en    = dslp_r[scdc_pkg::B_DS_EN];
   wire                ds_act   = ds_sync_r & ds_en;
   wire [CRYSTAL_SELECT_FIELD_FW-1:0]  crystal_select_field_cur = base_r[scdc_pkg::B_CRYSTAL_SELECT_FIELD_LO +: CRYSTAL_SELECT_FIELD_FW];
   wire [CRYSTAL_SELECT_FIELD_FW-1:0]  crystal_select_field_new = hwdata[scdc_pkg::B_CRYSTAL_SELECT_FIELD_LO +: CRYSTAL_SELECT_FIELD_FW];
   wire                byp_b    = base_r[scdc_pkg::B_BYP];
   wire                byp_e    = ext_r[scdc_pkg::B_BYP];
   wire                pdn_b    = base_r[scdc_pkg::B_PWRDN];
   wire                pdn_e    = ext_r[scdc_pkg::B_PWRDN];
   wire [1:0]          src_b    = base_r[scdc_pkg::B_SRC_LO +: 2];
   wire [1:0]          src_e    = ext_r[scdc_pkg::B_SRC_LO +: 2];
   wire [1:0]          src_d    = dslp_r[scdc_pkg::B_SRC_LO +: 2];
   wire [D2W-1:0]      div_b    = {2'b00, base_r[scdc_pkg::B_DIV_LO +: DW]};
   wire [D2W-1:0]      div_e    = ext_r[scdc_pkg::B_DIV_LO +: D2W];
   wire [D2W-1:0]      div_d    = dslp_r[scdc_pkg::B_DIV_LO +: D2W];

   wire [1:0]     src_run   = ovr ? src_e : src_b;
   wire           byp_run   = ovr ? byp_e : byp_b;
   wire           pwrdn_run = ovr ? pdn_e : pdn_b;
   wire [D2W-1:0] div_run   = ovr ? div_e : div_b;
   wire           wide      = ovr | ds_act;

   // deep sleep powers the pll down and runs divided from the source
   wire [1:0]     src_eff   = ds_act ? src_d : src_run;
   wire           byp_eff   = ds_act | byp_run;
   wire           pwrdn_eff = ds_act | pwrdn_run;
   wire [D2W-1:0] div_eff   = ds_act ? div_d : div_run;
   wire           usediv    = ds_act | base_r[scdc_pkg::B_USEDIV];

   // divisor arithmetic
   wire [VW-1:0]  div_plus1 = {1'b0, div_eff} + scdc_pkg::DVSR_ONE;
   wire           rsvd_b    = (div_eff[DW-1:0] < scdc_pkg::DIV_PLL_MIN)
                              | (div_eff[DW-1:0] == scdc_pkg::DIV_PLL_HOLE);
   wire           rsvd_e    = div_eff < scdc_pkg::DIV2_PLL_MIN;
   wire           pll_rsvd  = wide ? rsvd_e : rsvd_b;
   wire [VW-1:0]  pll_floor = {1'b0, scdc_pkg::DIV2_PLL_MIN} + scdc_pkg::DVSR_ONE;
   wire [VW-1:0]  pll_low_b = {3'b000, scdc_pkg::DIV_PLL_MIN} + scdc_pkg::DVSR_ONE;
   wire [VW-1:0]  pll_fix   = (!wide && div_eff[DW-1:0] < scdc_pkg::DIV_PLL_MIN)
                              ? pll_low_b : pll_floor;
   // reserved pll codes fall back to the nearest legal slower divisor
   wire [VW-1:0]  pll_dvsr  = pll_rsvd ? pll_fix : div_plus1;
   // bypassed, codes 0 and 1 both give two
   wire [VW-1:0]  byp_dvsr  = !usediv ? scdc_pkg::DVSR_ONE
                              : (div_eff <= scdc_pkg::DIV_BYP_TWO) ? scdc_pkg::DVSR_TWO
                              : div_plus1;

   // pll relock
   // a same-value crystal write leaves the pll locked
   wire           crystal_select_field_chg  = wr_base & (crystal_select_field_new != crystal_select_field_cur);
   wire           pll_up    = pwrdn_prev_r & ~pwrdn_eff;
   wire           relock_go = crystal_select_field_chg | pll_up;
   assign relock_nxt = relock_go ? RELOCK_COUNT
                     : (relock_r != '0) ? relock_r - 1'b1 : relock_r;
   wire           pll_ready = (relock_r == '0) & ~pwrdn_eff & ~relock_go;
   // wait on the selected oscillator until the pll is stable
   wire           use_pll   = ~byp_eff & pll_ready;
   wire [VW-1:0]  dvsr_eff  = use_pll ? pll_dvsr : byp_dvsr;

   wire [scdc_pkg::XLAT_W-1:0] xlat_val =
      PLL_XLAT[crystal_select_field_cur*scdc_pkg::XLAT_W +: scdc_pkg::XLAT_W];

   scdc_pkg::scdc_sel_t sel_nxt;
   assign sel_nxt.src     = scdc_pkg::scdc_src_t'(src_eff);
   assign sel_nxt.use_pll = use_pll;
   assign sel_nxt.divisor = dvsr_eff;

   // deep sleep swaps the main oscillator for the internal one
   wire main_oscillator_dis    = base_r[scdc_pkg::B_MAIN_OSCILLATOR_DIS];
   wire iosc_dis    = base_r[scdc_pkg::B_IOSC_DIS];
   wire main_en_nxt = ~main_oscillator_dis & ~ds_act;
   wire int_en_nxt  = ~iosc_dis | ds_act;

   // status word
   wire [31:0] stat_word;
   assign stat_word[scdc_pkg::S_RDY]                = pll_ready;
   assign stat_word[scdc_pkg::S_PLLSEL]             = use_pll;
   assign stat_word[scdc_pkg::S_RSVD]               = pll_rsvd & ~byp_eff;
   // unused status bits read zero
   assign stat_word[3]                              = 1'b0;
   assign stat_word[scdc_pkg::S_SRC_LO +: 2]        = src_eff;
   assign stat_word[7:6]                            = 2'b00;
   assign stat_word[scdc_pkg::S_DVSR_LO +: VW]      = dvsr_eff;
   assign stat_word[15]                             = 1'b0;
   assign stat_word[scdc_pkg::S_CNT_LO +: 16]       = relock_r;

   // read address decode
   wire [11:0] raddr     = haddr[11:0];
   wire        hit_base  = (raddr == scdc_pkg::OFS_BASE);
   wire        hit_ext   = (raddr == scdc_pkg::OFS_EXT);
   wire        hit_dslp  = (raddr == scdc_pkg::OFS_DSLP);
   wire        hit_gate  = (raddr == scdc_pkg::OFS_GATE);
   wire        hit_xlat  = (raddr == scdc_pkg::OFS_XLAT);
   wire        hit_stat  = (raddr == scdc_pkg::OFS_STAT);
   wire [31:0] gate_word = 32'(gate_nxt);
   wire [31:0] xlat_word = 32'(xlat_val);
   // read mux sees pending data-phase writes
   wire [31:0] rd_mux =
      hit_base ? base_nxt  :
      hit_ext  ? ext_nxt   :
      hit_dslp ? dslp_nxt  :
      hit_gate ? gate_word :
      hit_xlat ? xlat_word :
      hit_stat ? stat_word : 32'h0000_0000;
   wire rd_take = addr_phase & ~hwrite & word_ok;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         base_r <= scdc_pkg::RST_BASE;
         ext_r  <= scdc_pkg::RST_EXT;
         dslp_r <= scdc_pkg::RST_DSLP;
         gate_r <= '0;
      end else begin
         base_r <= base_nxt;
         ext_r  <= ext_nxt;
         dslp_r <= dslp_nxt;
         gate_r <= gate_nxt;
      end
   end

   // counter starts idle, the pll counts as powered down out of reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         relock_r     <= '0;
         pwrdn_prev_r <= 1'b1;
      end else begin
         relock_r     <= relock_nxt;
         pwrdn_prev_r <= pwrdn_eff;
      end
   end

   // two-stage synchroniser for the asynchronous sleep request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ds_meta_r <= 1'b0;
         ds_sync_r <= 1'b0;
      end else begin
         ds_meta_r <= deep_sleep_req;
         ds_sync_r <= ds_meta_r;
      end
   end

   // write data arrives one cycle after its address
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dph_wr_r   <= 1'b0;
         dph_addr_r <= '0;
      end else if (hready) begin
         dph_wr_r   <= addr_phase & hwrite & word_ok;
         dph_addr_r <= haddr[11:0];
      end
   end

   // read data stands until the next read is taken
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= '0;
      end else if (rd_take) begin
         hrdata <= rd_mux;
      end
   end

   // zero wait states, always okay
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // registered clock selection, internal oscillator from reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_sel.src     <= scdc_pkg::SRC_INT;
         clk_sel.use_pll <= 1'b0;
         clk_sel.divisor <= scdc_pkg::DVSR_ONE;
      end else begin
         clk_sel <= sel_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         main_osc_en <= 1'b0;
         int_osc_en  <= 1'b1;
         pll_pwr_on  <= 1'b0;
         pll_xlat    <= '0;
      end else begin
         main_osc_en <= main_en_nxt;
         int_osc_en  <= int_en_nxt;
         pll_pwr_on  <= ~pwrdn_eff;
         pll_xlat    <= xlat_val;
      end
   end

   // converter divide is fixed, independent of the system divisor
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         adc_clk_div   <= scdc_pkg::ADC_DIV;
         periph_clk_en <= '0;
      end else begin
         adc_clk_div   <= scdc_pkg::ADC_DIV;
         periph_clk_en <= gate_r;
      end
   end
endmodule
`default_nettype wire

//--- tb/scdc_monitor.sv
`default_nettype none
module scdc_monitor #(
   parameter int NPERIPH = 32
) (
   // clock and reset
   input wire logic                clk,
   input wire logic                rst_b,
   // register bus
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic                hready,
   input wire logic [31:0]         hrdata,
   // clock tree
   input wire scdc_pkg::scdc_sel_t clk_sel,
   input wire logic                pll_pwr_on,
   input wire logic [4:0]          adc_clk_div,
   input wire logic [NPERIPH-1:0]  periph_clk_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic take_w = hsel && htrans[1] && hready;
   wire logic gate_wr_w = take_w && hwrite && haddr[11:0] == scdc_pkg::OFS_GATE;

   a_adc_fixed_div: assert property (adc_clk_div == scdc_pkg::ADC_DIV)
      else $error("converter clock divide wrong");
   a_div_in_range: assert property (clk_sel.divisor != 7'h0 && clk_sel.divisor <= 7'h40)
      else $error("divisor out of range");
   a_pll_div_legal: assert property (clk_sel.use_pll |->
      clk_sel.divisor >= 7'h08 && clk_sel.divisor != 7'h09)
      else $error("reserved divisor on pll path");
   a_pll_needs_pwr: assert property (clk_sel.use_pll |-> pll_pwr_on)
      else $error("pll selected while powered down");
   a_relock_wait: assert property ($rose(pll_pwr_on) |-> (!clk_sel.use_pll) [*8])
      else $error("pll used before relock");
   a_reset_int_src: assert property ($rose(rst_b) |-> clk_sel.src == scdc_pkg::SRC_INT)
      else $error("source not internal after reset");
   a_rdata_holds: assert property (!(take_w && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   a_gate_by_write: assert property ($changed(periph_clk_en) |-> $past(gate_wr_w, 3))
      else $error("peripheral gate moved without a write");

   c_pll_div64: cover property (clk_sel.use_pll && clk_sel.divisor == 7'h40);
   c_pll_rise: cover property ($rose(clk_sel.use_pll));
   c_gate_move: cover property ($changed(periph_clk_en));
endmodule
bind scdc_core scdc_monitor #(.NPERIPH(NPERIPH)) u_scdc_mon (
   .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .clk_sel(clk_sel),
   .pll_pwr_on(pll_pwr_on), .adc_clk_div(adc_clk_div), .periph_clk_en(periph_clk_en)
);
`default_nettype wire

//--- tb/scdc_core_tb.sv
`default_nettype none
module scdc_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          NP = 8;
   localparam int          WT = 24;
   localparam logic [11:0] OB = scdc_pkg::OFS_BASE;
   localparam logic [11:0] OE = scdc_pkg::OFS_EXT;
   localparam logic [223:0] XL = {8{14'h2A5B, 14'h1C3D}};
   typedef struct packed {
      logic [11:0]         ofs;
      logic [31:0]         dat;
      scdc_pkg::scdc_sel_t exp;
   } scdc_row_t;
   logic                clk, rst_b, hsel, hwrite, hreadyout, hresp, deep_sleep_req;
   logic                main_osc_en, int_osc_en, pll_pwr_on;
   logic [31:0]         haddr, hwdata, hrdata, rd;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic [4:0]          adc_clk_div;
   logic [13:0]         pll_xlat;
   logic [NP-1:0]       periph_clk_en;
   scdc_pkg::scdc_sel_t clk_sel;
   int                  error_cnt = 0;
   int                  checks = 0;
   int                  cyc = 0;
   scdc_row_t           rows [14];

   scdc_core #(.NPERIPH(NP), .RELOCK_COUNT(16'h0010), .PLL_XLAT(XL)) DUT (
      .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .deep_sleep_req(deep_sleep_req), .clk_sel(clk_sel), .main_osc_en(main_osc_en),
      .int_osc_en(int_osc_en), .pll_pwr_on(pll_pwr_on), .pll_xlat(pll_xlat),
      .adc_clk_div(adc_clk_div), .periph_clk_en(periph_clk_en)
   );

   task automatic end_of_test;
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp_w(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic cmp_sel(input scdc_pkg::scdc_sel_t e);
      cmp_w("clk_sel", {22'h0, e}, {22'h0, clk_sel});
   endtask

   // one single word transfer, read data lands in rd
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {20'h0, a};
      @(posedge clk);
      while (hreadyout !== 1'h1) @(posedge clk);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'h1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         end_of_test;
      end
   end

   initial begin
      rst_b = 1'h0;
      hsel = 1'h0;
      hwrite = 1'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      hsize = scdc_pkg::HSIZE_WORD;
      deep_sleep_req = 1'h0;
      rows = '{
         {OB, 32'h07802AC0, 2'h0, 1'h0, 7'h01},
         {OB, 32'h00402AC0, 2'h0, 1'h0, 7'h02},
         {OB, 32'h00C02AC0, 2'h0, 1'h0, 7'h02},
         {OB, 32'h07C02AC0, 2'h0, 1'h0, 7'h10},
         {OB, 32'h03C002C0, 2'h0, 1'h1, 7'h08},
         {OB, 32'h04C002C0, 2'h0, 1'h1, 7'h0A},
         {OB, 32'h044002C0, 2'h0, 1'h1, 7'h0A},
         {OB, 32'h01C002C0, 2'h0, 1'h1, 7'h08},
         {OE, 32'h9F800000, 2'h0, 1'h1, 7'h40},
         {OE, 32'h82800000, 2'h0, 1'h1, 7'h0A},
         {OE, 32'h80000810, 2'h1, 1'h0, 7'h02},
         {OE, 32'h9F800820, 2'h2, 1'h0, 7'h40},
         {OE, 32'h1F800820, 2'h0, 1'h1, 7'h08},
         {OB, 32'h07802AD1, 2'h1, 1'h0, 7'h01}};
      repeat (8) @(posedge clk);
      rst_b <= 1'h1;
      foreach (rows[i]) begin
         bus(1'h1, rows[i].ofs, rows[i].dat);
         settle(WT);
         cmp_sel(rows[i].exp);
      end
      cmp_w("xlat", 32'h2A5B, {18'h0, pll_xlat});
      // relock only on a real change
      bus(1'h1, OB, 32'h01C002C0);
      settle(4);
      cmp_w("use_pll", 32'h0, {31'h0, clk_sel.use_pll});
      settle(WT);
      cmp_sel({2'h0, 1'h1, 7'h08});
      bus(1'h1, OB, 32'h01C002C0);
      settle(4);
      cmp_w("use_pll", 32'h1, {31'h0, clk_sel.use_pll});
      bus(1'h1, OB, 32'h01C00300);
      settle(4);
      cmp_w("use_pll", 32'h0, {31'h0, clk_sel.use_pll});
      cmp_w("xlat", 32'h1C3D, {18'h0, pll_xlat});
      settle(WT);
      cmp_w("use_pll", 32'h1, {31'h0, clk_sel.use_pll});
      bus(1'h0, scdc_pkg::OFS_XLAT, 32'h0);
      cmp_w("xlat_reg", 32'h1C3D, rd);
      bus(1'h0, scdc_pkg::OFS_STAT, 32'h0);
      cmp_w("stat", 32'h0000_0807, rd);
      // deep sleep takes over source and divider
      bus(1'h1, scdc_pkg::OFS_DSLP, 32'h1F800011);
      bus(1'h0, scdc_pkg::OFS_DSLP, 32'h0);
      cmp_w("dslp", 32'h1F800011, rd);
      @(posedge clk);
      deep_sleep_req <= 1'h1;
      settle(6);
      cmp_sel({2'h1, 1'h0, 7'h40});
      cmp_w("osc", 32'h1, {30'h0, main_osc_en, int_osc_en});
      cmp_w("pll_pwr", 32'h0, {31'h0, pll_pwr_on});
      @(posedge clk);
      deep_sleep_req <= 1'h0;
      settle(WT + 4);
      cmp_sel({2'h0, 1'h1, 7'h08});
      bus(1'h1, scdc_pkg::OFS_GATE, 32'h000000A5);
      settle(3);
      cmp_w("gate", 32'hA5, {24'h0, periph_clk_en});
      bus(1'h1, 12'h200, 32'hFFFFFFFF);
      bus(1'h0, 12'h200, 32'h0);
      cmp_w("unmapped", 32'h0, rd);
      // reset in mid-run
      @(posedge clk);
      rst_b <= 1'h0;
      settle(2);
      cmp_sel({2'h1, 1'h0, 7'h01});
      cmp_w("adc", 32'h19, {27'h0, adc_clk_div});
      cmp_w("pwr", 32'h1, {29'h0, pll_pwr_on, main_osc_en, int_osc_en});
      cmp_w("gate", 32'h0, {24'h0, periph_clk_en});
      cmp_w("resp", 32'h2, {30'h0, hreadyout, hresp});
      @(posedge clk);
      rst_b <= 1'h1;
      settle(1);
      cmp_sel({2'h1, 1'h0, 7'h01});
      bus(1'h0, OB, 32'h0);
      cmp_w("base", scdc_pkg::RST_BASE, rd);
      bus(1'h0, OE, 32'h0);
      cmp_w("ext", scdc_pkg::RST_EXT, rd);
      end_of_test;
   end
endmodule
`default_nettype wire
